// ===== design/mpc_pkg.sv
package mpc_pkg;

    // ****************************************
    // Modes
    // ****************************************
    typedef enum logic [2:0] {
        CFG_ONE   = 3'h0,
        CFG_TWO   = 3'h1,
        CFG_TOTAL = 3'h2,
        CFG_BATCH = 3'h3,
        CFG_DUAL  = 3'h4,
        CFG_TACHO = 3'h5
    } mpc_config_t;

    typedef enum logic [2:0] {
        IN_INC  = 3'h0,
        IN_DEC  = 3'h1,
        IN_CMD  = 3'h2,
        IN_IND  = 3'h3,
        IN_QUAD = 3'h4
    } mpc_in_mode_t;

    typedef enum logic [1:0] {
        OUT_HOLD  = 2'h0,
        OUT_LEVEL = 2'h1,
        OUT_PULSE = 2'h2
    } mpc_out_mode_t;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic count_pulse_in_a;
        logic count_pulse_in_b;
        logic clear_pri;
        logic clear_sec;
    } mpc_pins_t;

    typedef struct packed {
        mpc_config_t   cfg_sel;
        mpc_in_mode_t  in_mode;
        mpc_out_mode_t out_one_mode;
        mpc_out_mode_t out_two_mode;
        logic [1:0]    alloc;
    } mpc_settings_t;

    // ****************************************
    // Widths, reset values, timing
    // ****************************************
    localparam int unsigned PV_WIDTH         = 20;
    localparam logic [3:0]  PIN_RESET        = 4'h0;
    localparam logic        OUT_RESET        = 1'b0;
    localparam int unsigned CLK_HZ           = 125_000_000;
    localparam int unsigned ONE_SHOT_MS      = 100;
    localparam int unsigned ONE_SHOT_CYCLES  = CLK_HZ / 1000 * ONE_SHOT_MS;
    localparam int unsigned TACHO_GATE_MS    = 1000;
    localparam int unsigned TACHO_GATE_CYCLES = CLK_HZ / 1000 * TACHO_GATE_MS;

endpackage : mpc_pkg

// ===== design/mpc_in_sync.sv
`timescale 1ns/1ns
module mpc_in_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] rise_out
);
    import mpc_pkg::*;

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] lvl_reg;
    logic [WIDTH-1:0] rise_reg;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] lvl_next;

    // Accept a change once stages two and three agree
    assign agree    = ~(s2_reg ^ s3_reg);
    assign lvl_next = (lvl_reg & ~agree) | (s3_reg & agree);

    // Three-stage chain, filtered level, rising edge
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s1_reg   <= PIN_RESET[WIDTH-1:0];
            s2_reg   <= PIN_RESET[WIDTH-1:0];
            s3_reg   <= PIN_RESET[WIDTH-1:0];
            lvl_reg  <= PIN_RESET[WIDTH-1:0];
            rise_reg <= PIN_RESET[WIDTH-1:0];
        end else begin
            s1_reg   <= raw_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            lvl_reg  <= lvl_next;
            rise_reg <= lvl_next & ~lvl_reg;
        end
    end

    assign level_out = lvl_reg;
    assign rise_out  = rise_reg;

endmodule : mpc_in_sync

// ===== design/mpc_stage_out.sv
`timescale 1ns/1ns
module mpc_stage_out #(
    parameter int unsigned PULSE_CYCLES = mpc_pkg::ONE_SHOT_CYCLES
) (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_in,
    input  mpc_pkg::mpc_out_mode_t     mode_in,
    input  wire logic                  reach_in,
    input  wire logic                  clear_in,
    input  wire logic                  freeze_in,
    output logic                       stage_out
);
    import mpc_pkg::*;

    logic        reach_d_reg;
    logic        out_reg;
    logic        out_next;
    logic [31:0] pulse_reg;
    logic [31:0] pulse_next;
    logic        reach_rise;

    assign reach_rise = reach_in & ~reach_d_reg;

    // Output behaviour per selected mode
    always_comb begin
        out_next   = out_reg;
        pulse_next = pulse_reg;
        if (freeze_in) begin
            out_next = out_reg;
        end else if (clear_in) begin
            out_next   = OUT_RESET;
            pulse_next = 32'h0;
        end else begin
            unique case (mode_in)
                OUT_HOLD:  out_next = out_reg | reach_rise;
                OUT_LEVEL: out_next = reach_in;
                OUT_PULSE: begin
                    if (reach_rise) begin
                        pulse_next = PULSE_CYCLES;
                    end else if (pulse_reg != 32'h0) begin
                        pulse_next = pulse_reg - 32'h1;
                    end
                    out_next = reach_rise | (pulse_reg > 32'h1);
                end
                default: out_next = OUT_RESET;
            endcase
        end
    end

    // State registers
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            reach_d_reg <= 1'b0;
            out_reg     <= OUT_RESET;
            pulse_reg   <= 32'h0;
        end else begin
            reach_d_reg <= freeze_in ? reach_d_reg : reach_in;
            out_reg     <= out_next;
            pulse_reg   <= pulse_next;
        end
    end

    assign stage_out = out_reg;

endmodule : mpc_stage_out

// ===== design/mpc_counter_top.sv
`timescale 1ns/1ns
module mpc_counter_top #(
    parameter int unsigned PV_W        = mpc_pkg::PV_WIDTH,
    parameter int unsigned ONE_SHOT_CYC = mpc_pkg::ONE_SHOT_CYCLES,
    parameter int unsigned GATE_CYC     = mpc_pkg::TACHO_GATE_CYCLES
) (
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_in,
    input  mpc_pkg::mpc_pins_t        pins_in,
    input  mpc_pkg::mpc_settings_t    settings_in,
    input  wire logic [PV_W-1:0]      set_one_in,
    input  wire logic [PV_W-1:0]      set_two_in,
    output logic      [PV_W-1:0]      present_out,
    output logic      [PV_W-1:0]      aux_out,
    output logic                      stage_one_output_out,
    output logic                      stage_two_output_out,
    output logic                      clear_lamp_out
);
    import mpc_pkg::*;

    // ****************************************
    // Direction decode
    // ****************************************
    // Returns {up, down} for one clock
    function automatic logic [1:0] step_dir(
        input mpc_in_mode_t mode,
        input logic         rise_a,
        input logic         rise_b,
        input logic         lvl_b
    );
        logic [1:0] r;
        r = 2'h0;
        unique case (mode)
            IN_INC:  r = {rise_a, 1'b0};
            IN_DEC:  r = {1'b0, rise_a};
            IN_CMD:  r = {rise_a & ~lvl_b, rise_a & lvl_b};
            IN_IND:  r = {rise_a & ~rise_b, rise_b & ~rise_a};
            IN_QUAD: r = {rise_a & ~lvl_b, rise_a & lvl_b};
            default: r = 2'h0;
        endcase
        return r;
    endfunction : step_dir

    // Compares with a fixed width
    function automatic logic at_least(
        input logic [PV_W-1:0] value,
        input logic [PV_W-1:0] limit
    );
        return value >= limit;
    endfunction : at_least

    // ****************************************
    // Input synchronisation
    // ****************************************
    mpc_pins_t  pin_lvl;
    mpc_pins_t  pin_rise;
    logic [3:0] lvl_bits;
    logic [3:0] rise_bits;

    mpc_in_sync #(
        .WIDTH (4)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .raw_in     (pins_in),
        .level_out  (lvl_bits),
        .rise_out   (rise_bits)
    );

    assign pin_lvl  = mpc_pins_t'(lvl_bits);
    assign pin_rise = mpc_pins_t'(rise_bits);

    // ****************************************
    // Mode decode
    // ****************************************
    mpc_config_t  cfg;
    mpc_in_mode_t imode;
    logic         is_one;
    logic         is_total;
    logic         is_batch;
    logic         is_dual;
    logic         is_tacho;
    logic         is_dec;
    logic         clr_p;
    logic         clr_s;

    assign cfg      = settings_in.cfg_sel;
    assign imode    = settings_in.in_mode;
    assign is_one   = (cfg == CFG_ONE);
    assign is_total = (cfg == CFG_TOTAL);
    assign is_batch = (cfg == CFG_BATCH);
    assign is_dual  = (cfg == CFG_DUAL);
    assign is_tacho = (cfg == CFG_TACHO);
    assign is_dec   = (imode == IN_DEC);
    assign clr_p    = pin_lvl.clear_pri;
    // Secondary clear only where the mode uses it
    assign clr_s    = pin_lvl.clear_sec & (is_total | is_batch | is_dual);

    // ****************************************
    // Count steps
    // ****************************************
    logic [1:0] dir;
    logic       step_up;
    logic       step_dn;
    logic       rise_a;
    logic       rise_b;

    assign rise_a  = pin_rise.count_pulse_in_a;
    assign rise_b  = pin_rise.count_pulse_in_b;
    assign dir     = step_dir(imode, rise_a, rise_b, pin_lvl.count_pulse_in_b);
    // Paired stepping off in dual and tachometer modes
    assign step_up = dir[1] & ~clr_p & ~is_dual & ~is_tacho;
    assign step_dn = dir[0] & ~clr_p & ~is_dual & ~is_tacho;

    // ****************************************
    // Present value and reach
    // ****************************************
    logic [PV_W-1:0] pv_reg;
    logic [PV_W-1:0] pv_next;
    logic [PV_W-1:0] aux_reg;
    logic [PV_W-1:0] aux_next;
    logic [PV_W-1:0] pv_load;
    logic [PV_W-1:0] one_dec_tgt;
    logic [PV_W-1:0] dual_sum;
    logic            reach_pv_one;
    logic            reach_pv_two;
    logic            batch_wrap;

    // Clear value: zero, or set value when counting down
    assign pv_load = is_dec ? (is_one ? set_one_in : set_two_in) : '0;
    // Counting down, stage one fires after set-one pulses
    assign one_dec_tgt  = is_one ? '0 : (set_two_in - set_one_in);
    assign reach_pv_one = is_dec ? (pv_reg <= one_dec_tgt) : at_least(pv_reg, set_one_in);
    assign reach_pv_two = is_dec ? (pv_reg == '0) : at_least(pv_reg, set_two_in);
    assign batch_wrap   = is_batch & reach_pv_two & ~clr_p;
    assign dual_sum     = pv_reg + aux_reg;

    // Next present value per configuration
    always_comb begin
        pv_next = pv_reg;
        if (is_tacho) begin
            pv_next = pv_reg;
        end else if (is_dual) begin
            if (clr_p) begin
                pv_next = '0;
            end else if (rise_a) begin
                pv_next = pv_reg + 1'b1;
            end
        end else if (clr_p) begin
            pv_next = pv_load;
        end else if (batch_wrap) begin
            pv_next = pv_load;
        end else if (step_up) begin
            pv_next = pv_reg + 1'b1;
        end else if (step_dn) begin
            pv_next = pv_reg - 1'b1;
        end
    end

    // Total, batch count or channel B
    always_comb begin
        aux_next = aux_reg;
        if (is_total) begin
            if (clr_s) begin
                aux_next = '0;
            end else if (step_up) begin
                aux_next = aux_reg + 1'b1;
            end else if (step_dn) begin
                aux_next = aux_reg - 1'b1;
            end
        end else if (is_batch) begin
            if (clr_s) begin
                aux_next = '0;
            end else if (batch_wrap) begin
                aux_next = aux_reg + 1'b1;
            end
        end else if (is_dual) begin
            if (clr_s) begin
                aux_next = '0;
            end else if (rise_b) begin
                aux_next = aux_reg + 1'b1;
            end
        end
    end

    // ****************************************
    // Tachometer gate
    // ****************************************
    logic [31:0]     gate_reg;
    logic [PV_W-1:0] acc_reg;
    logic [PV_W-1:0] meas_reg;
    logic            gate_end;
    logic [PV_W-1:0] acc_plus;

    assign gate_end = (gate_reg == GATE_CYC - 1);
    assign acc_plus = acc_reg + {{(PV_W-1){1'b0}}, rise_a};

    // Pulses on input A per gate window
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            gate_reg <= 32'h0;
            acc_reg  <= '0;
            meas_reg <= '0;
        end else if (!is_tacho) begin
            gate_reg <= 32'h0;
            acc_reg  <= '0;
            meas_reg <= '0;
        end else if (gate_end) begin
            gate_reg <= 32'h0;
            acc_reg  <= '0;
            meas_reg <= clr_p ? meas_reg : acc_plus;
        end else begin
            gate_reg <= gate_reg + 32'h1;
            acc_reg  <= acc_plus;
        end
    end

    // ****************************************
    // Stage outputs
    // ****************************************
    logic reach_one;
    logic reach_two;
    logic clear_one;
    logic clear_two;
    logic freeze;
    logic stage_one;
    logic stage_two;

    // Reach per configuration
    assign reach_one = is_tacho ? at_least(meas_reg, set_one_in) :
                       is_batch ? at_least(aux_reg, set_one_in) :
                       is_dual  ? at_least(dual_sum, set_one_in) :
                       reach_pv_one;
    assign reach_two = is_tacho ? at_least(meas_reg, set_two_in) :
                       is_dual  ? at_least(dual_sum, set_two_in) :
                       is_one   ? 1'b0 : reach_pv_two;
    // Which clear drops which output
    assign clear_one = is_tacho ? 1'b0 : is_batch ? clr_s :
                       is_dual  ? (clr_p | clr_s) : clr_p;
    assign clear_two = is_tacho ? 1'b0 : is_dual ? (clr_p | clr_s) : clr_p;
    assign freeze    = is_tacho & clr_p;

    mpc_stage_out #(
        .PULSE_CYCLES (ONE_SHOT_CYC)
    ) u_stage_one (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .mode_in    (settings_in.out_one_mode),
        .reach_in   (reach_one),
        .clear_in   (clear_one),
        .freeze_in  (freeze),
        .stage_out  (stage_one)
    );

    mpc_stage_out #(
        .PULSE_CYCLES (ONE_SHOT_CYC)
    ) u_stage_two (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .mode_in    (settings_in.out_two_mode),
        .reach_in   (reach_two),
        .clear_in   (clear_two),
        .freeze_in  (freeze),
        .stage_out  (stage_two)
    );

    // ****************************************
    // Output registers
    // ****************************************
    logic            phys_one_next;
    logic            phys_two_next;
    logic            phys_one_reg;
    logic            phys_two_reg;
    logic            lamp_reg;
    logic [PV_W-1:0] present_reg;
    logic [PV_W-1:0] aux_out_reg;

    // Output allocation to either stage
    assign phys_one_next = settings_in.alloc[0] ? stage_two : stage_one;
    assign phys_two_next = settings_in.alloc[1] ? stage_one : stage_two;

    // Counters and displayed values
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pv_reg       <= '0;
            aux_reg      <= '0;
            phys_one_reg <= OUT_RESET;
            phys_two_reg <= OUT_RESET;
            lamp_reg     <= 1'b0;
            present_reg  <= '0;
            aux_out_reg  <= '0;
        end else begin
            pv_reg       <= pv_next;
            aux_reg      <= aux_next;
            phys_one_reg <= phys_one_next;
            phys_two_reg <= phys_two_next;
            lamp_reg     <= clr_p;
            present_reg  <= is_tacho ? meas_reg : pv_reg;
            aux_out_reg  <= aux_reg;
        end
    end

    assign present_out          = present_reg;
    assign aux_out              = aux_out_reg;
    assign stage_one_output_out = phys_one_reg;
    assign stage_two_output_out = phys_two_reg;
    assign clear_lamp_out       = lamp_reg;

endmodule : mpc_counter_top

// ===== verification/mpc_counter_props.sv
`timescale 1ns/1ns
// ****
// Port checker
// ****
module mpc_counter_props #(
    parameter int unsigned PV_W         = 20,
    parameter int unsigned ONE_SHOT_CYC = 8,
    parameter int unsigned GATE_CYC     = 16
) (
    input wire logic              ref_clk_in,
    input wire logic              rst_in,
    input mpc_pkg::mpc_pins_t     pins_in,
    input mpc_pkg::mpc_settings_t settings_in,
    input wire logic [PV_W-1:0]   set_one_in,
    input wire logic [PV_W-1:0]   set_two_in,
    input wire logic [PV_W-1:0]   present_out,
    input wire logic [PV_W-1:0]   aux_out,
    input wire logic              stage_one_output_out,
    input wire logic              stage_two_output_out,
    input wire logic              clear_lamp_out
);
    import mpc_pkg::*;
    // Short names
    wire         clr_p = pins_in.clear_pri;
    wire         clr_s = pins_in.clear_sec;
    wire         cnt_a = pins_in.count_pulse_in_a;
    wire         cnt_b = pins_in.count_pulse_in_b;
    wire         stage_one_output  = stage_one_output_out;
    wire         stage_two_output  = stage_two_output_out;
    mpc_config_t cfg;
    assign cfg = settings_in.cfg_sel;
    // High run length of stage one
    int unsigned hi_cnt_reg;
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !stage_one_output) hi_cnt_reg <= 0;
        else hi_cnt_reg <= hi_cnt_reg + 1;
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // Clears past sync
    sequence s_pri_held; clr_p [*8]; endsequence
    sequence s_sec_held; clr_s [*8]; endsequence

    property p_lamp_on; clr_p [*6] |-> clear_lamp_out; endproperty
    a_lamp_on: assert property (p_lamp_on) else $error("lamp dark");
    property p_lamp_off; (!clr_p) [*6] |-> !clear_lamp_out; endproperty
    a_lamp_off: assert property (p_lamp_off) else $error("lamp lit");
    property p_pri_zero;
        s_pri_held ##0 (cfg != CFG_TACHO && settings_in.in_mode != IN_DEC) |-> present_out == '0;
    endproperty
    a_pri_zero: assert property (p_pri_zero) else $error("value not zero");
    property p_pri_reload;
        s_pri_held ##0 (cfg < CFG_DUAL && settings_in.in_mode == IN_DEC)
            |-> present_out == ((cfg == CFG_ONE) ? set_one_in : set_two_in);
    endproperty
    a_pri_reload: assert property (p_pri_reload) else $error("bad reload");
    property p_pri_outs;
        s_pri_held ##0 (cfg != CFG_TACHO && cfg != CFG_BATCH) |-> !stage_one_output && !stage_two_output;
    endproperty
    a_pri_outs: assert property (p_pri_outs) else $error("outputs on");
    property p_sec_aux;
        s_sec_held ##0 (cfg inside {CFG_TOTAL, CFG_BATCH, CFG_DUAL}) |-> aux_out == '0;
    endproperty
    a_sec_aux: assert property (p_sec_aux) else $error("aux not zero");
    property p_batch_out;
        s_sec_held ##0 (cfg == CFG_BATCH && settings_in.alloc == 2'h0) |-> !stage_one_output;
    endproperty
    a_batch_out: assert property (p_batch_out) else $error("batch output on");
    property p_sec_ignored;
        (!cnt_a && !cnt_b && !clr_p && cfg <= CFG_TWO) [*8] |-> $stable(present_out);
    endproperty
    a_sec_ignored: assert property (p_sec_ignored) else $error("value moved idle");
    property p_tacho_freeze;
        s_pri_held ##0 (cfg == CFG_TACHO) |=> $stable(present_out) && $stable(stage_one_output) && $stable(stage_two_output);
    endproperty
    a_tacho_freeze: assert property (p_tacho_freeze) else $error("hold not frozen");
    property p_pulse_width;
        $fell(stage_one_output) && settings_in.out_one_mode == OUT_PULSE && settings_in.alloc == 2'h0
            && cfg != CFG_TACHO && !clr_p && !clr_s |-> hi_cnt_reg == ONE_SHOT_CYC;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("shot width");
    property p_level;
        cfg == CFG_ONE && settings_in.in_mode == IN_INC && settings_in.out_one_mode == OUT_LEVEL
            && settings_in.alloc == 2'h0 && !clr_p && present_out >= set_one_in |-> ##[1:2] stage_one_output;
    endproperty
    a_level: assert property (p_level) else $error("level missing");
endmodule : mpc_counter_props

bind mpc_counter_top mpc_counter_props #(
    .PV_W(PV_W), .ONE_SHOT_CYC(ONE_SHOT_CYC), .GATE_CYC(GATE_CYC)
) u_props (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .pins_in(pins_in), .settings_in(settings_in),
    .set_one_in(set_one_in), .set_two_in(set_two_in), .present_out(present_out), .aux_out(aux_out),
    .stage_one_output_out(stage_one_output_out), .stage_two_output_out(stage_two_output_out),
    .clear_lamp_out(clear_lamp_out)
);

// ===== verification/mpc_sensor_model.sv
`timescale 1ns/1ns
// ****
// Input pin model
// ****
module mpc_sensor_model (
    input  wire logic         ref_clk_in,
    output mpc_pkg::mpc_pins_t pins_out
);
    import mpc_pkg::*;
    // Contacts open
    initial pins_out = PIN_RESET;

    // Pulse trains
    task automatic pulse(input logic a, input logic b, input int n, input int w);
        repeat (n) begin
            @(posedge ref_clk_in);
            #1;
            if (a) pins_out.count_pulse_in_a = 1'b1;
            if (b) pins_out.count_pulse_in_b = 1'b1;
            repeat (w) @(posedge ref_clk_in);
            #1;
            if (a) pins_out.count_pulse_in_a = 1'b0;
            if (b) pins_out.count_pulse_in_b = 1'b0;
            repeat (w - 1) @(posedge ref_clk_in);
        end
    endtask : pulse

    // Clear levels
    task automatic clears(input logic pri, input logic sec);
        @(posedge ref_clk_in);
        #1;
        pins_out.clear_pri = pri;
        pins_out.clear_sec = sec;
    endtask : clears

    // Level on input b
    task automatic b_level(input logic v);
        @(posedge ref_clk_in);
        #1;
        pins_out.count_pulse_in_b = v;
    endtask : b_level
endmodule : mpc_sensor_model

// ===== verification/tb.sv
`timescale 1ns/1ns
// ****
// Testbench
// ****
module tb;
    import mpc_pkg::*;
    logic          ref_clk;
    logic          rst;
    mpc_pins_t     pins;
    mpc_settings_t sets;
    logic [19:0]   set_one;
    logic [19:0]   set_two;
    logic [19:0]   present;
    logic [19:0]   aux;
    logic          stage_one_output;
    logic          stage_two_output;
    logic          lamp;
    int            err_total;
    int            n_checks;
    // Widened 1-bit outputs
    wire  [19:0]   o1_w   = {19'h0, stage_one_output};
    wire  [19:0]   o2_w   = {19'h0, stage_two_output};
    wire  [19:0]   lamp_w = {19'h0, lamp};

    // 8 ns clock
    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;

    mpc_sensor_model SNS (.ref_clk_in(ref_clk), .pins_out(pins));
    mpc_counter_top #(.ONE_SHOT_CYC(8), .GATE_CYC(16)) DUT (
        .ref_clk_in(ref_clk), .rst_in(rst), .pins_in(pins), .settings_in(sets),
        .set_one_in(set_one), .set_two_in(set_two), .present_out(present), .aux_out(aux),
        .stage_one_output_out(stage_one_output), .stage_two_output_out(stage_two_output), .clear_lamp_out(lamp)
    );

    // ****
    // Helpers
    // ****
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic restart(input mpc_config_t c, input mpc_in_mode_t m, input mpc_out_mode_t o1,
                           input mpc_out_mode_t o2, input logic [1:0] al, input logic [19:0] s1, s2);
        tick(1);
        rst = 1'b1;
        sets = '{c, m, o1, o2, al};
        set_one = s1;
        set_two = s2;
        tick(4);
        rst = 1'b0;
        tick(2);
    endtask : restart

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // ****
    // Scenarios
    // ****
    task automatic t_modes;
        logic [19:0] exp_tab [5] = '{20'h6, 20'h18, 20'h2, 20'h4, 20'h2};
        for (int i = 0; i < 5; i++) begin
            restart(CFG_TWO, mpc_in_mode_t'(i), OUT_HOLD, OUT_HOLD, 2'h0, 20'h14, 20'h1e);
            SNS.clears(1'b1, 1'b0);
            tick(8);
            SNS.clears(1'b0, 1'b0);
            tick(8);
            chk("reload", (i == 1) ? 20'h1e : 20'h0, present);
            SNS.pulse(1'b1, 1'b0, 4, 3);
            SNS.pulse(1'b0, 1'b1, 1, 3);
            SNS.b_level(1'b1);
            SNS.pulse(1'b1, 1'b0, 2, 3);
            SNS.b_level(1'b0);
            tick(10);
            chk("paired count", exp_tab[i], present);
        end
        $display("test modes done");
    endtask : t_modes

    task automatic t_clear;
        restart(CFG_ONE, IN_INC, OUT_LEVEL, OUT_HOLD, 2'h0, 20'h3, 20'h5);
        SNS.pulse(1'b1, 1'b0, 4, 3);
        tick(4);
        chk("count", 20'h4, present);
        chk("level out", 20'h1, o1_w);
        SNS.clears(1'b1, 1'b0);
        SNS.pulse(1'b1, 1'b0, 3, 3);
        chk("lamp", 20'h1, lamp_w);
        chk("held value", 20'h0, present);
        chk("out cleared", 20'h0, o1_w);
        SNS.clears(1'b0, 1'b1);
        tick(8);
        chk("lamp sec", 20'h0, lamp_w);
        SNS.pulse(1'b1, 1'b0, 1, 3);
        tick(8);
        chk("sec ignored", 20'h1, present);
        SNS.clears(1'b0, 1'b0);
        $display("test clear done");
    endtask : t_clear

    task automatic t_total;
        restart(CFG_TOTAL, IN_INC, OUT_HOLD, OUT_HOLD, 2'h0, 20'h64, 20'hc8);
        SNS.pulse(1'b1, 1'b0, 5, 3);
        tick(8);
        chk("total", 20'h5, aux);
        SNS.clears(1'b0, 1'b1);
        tick(10);
        chk("total held", 20'h0, aux);
        chk("value kept", 20'h5, present);
        SNS.clears(1'b0, 1'b0);
        SNS.pulse(1'b1, 1'b0, 1, 3);
        tick(8);
        chk("total again", 20'h1, aux);
        $display("test total done");
    endtask : t_total

    task automatic t_batch;
        restart(CFG_BATCH, IN_INC, OUT_HOLD, OUT_HOLD, 2'h0, 20'h1, 20'h2);
        SNS.pulse(1'b1, 1'b0, 2, 3);
        tick(8);
        chk("batch count", 20'h1, aux);
        chk("batch out", 20'h1, o1_w);
        chk("stage two", 20'h1, o2_w);
        SNS.clears(1'b1, 1'b0);
        tick(10);
        chk("stage two clr", 20'h0, o2_w);
        chk("batch out kept", 20'h1, o1_w);
        SNS.clears(1'b0, 1'b1);
        tick(10);
        chk("batch clr", 20'h0, aux);
        chk("batch out clr", 20'h0, o1_w);
        SNS.clears(1'b0, 1'b0);
        $display("test batch done");
    endtask : t_batch

    task automatic t_dual;
        restart(CFG_DUAL, IN_INC, OUT_HOLD, OUT_HOLD, 2'h0, 20'h64, 20'h64);
        SNS.pulse(1'b1, 1'b0, 3, 3);
        SNS.pulse(1'b0, 1'b1, 2, 3);
        tick(8);
        chk("chan a", 20'h3, present);
        chk("chan b", 20'h2, aux);
        SNS.clears(1'b1, 1'b0);
        SNS.pulse(1'b1, 1'b1, 1, 3);
        tick(8);
        chk("chan a clr", 20'h0, present);
        chk("chan b runs", 20'h3, aux);
        chk("lamp dual", 20'h1, lamp_w);
        SNS.clears(1'b0, 1'b1);
        SNS.pulse(1'b1, 1'b1, 1, 3);
        tick(8);
        chk("chan b clr", 20'h0, aux);
        chk("chan a runs", 20'h1, present);
        SNS.clears(1'b0, 1'b0);
        $display("test dual done");
    endtask : t_dual

    task automatic t_tacho;
        restart(CFG_TACHO, IN_INC, OUT_LEVEL, OUT_LEVEL, 2'h0, 20'h2, 20'h3);
        fork
            SNS.pulse(1'b1, 1'b1, 12, 4);
        join_none
        tick(52);
        chk("rate", 20'h2, present);
        chk("tacho stage_one_output", 20'h1, o1_w);
        chk("tacho stage_two_output", 20'h0, o2_w);
        SNS.clears(1'b1, 1'b0);
        tick(80);
        chk("rate frozen", 20'h2, present);
        chk("out frozen", 20'h1, o1_w);
        chk("lamp hold", 20'h1, lamp_w);
        SNS.clears(1'b0, 1'b0);
        tick(40);
        chk("rate idle", 20'h0, present);
        $display("test tacho done");
    endtask : t_tacho

    task automatic t_outs;
        restart(CFG_TWO, IN_INC, OUT_HOLD, OUT_HOLD, 2'h3, 20'h2, 20'h4);
        SNS.pulse(1'b1, 1'b0, 2, 3);
        tick(8);
        chk("swap stage_one_output", 20'h0, o1_w);
        chk("swap stage_two_output", 20'h1, o2_w);
        SNS.pulse(1'b1, 1'b0, 2, 3);
        tick(8);
        chk("swap both", 20'h1, o1_w);
        restart(CFG_ONE, IN_INC, OUT_PULSE, OUT_HOLD, 2'h0, 20'h1, 20'h1);
        SNS.pulse(1'b1, 1'b0, 1, 3);
        tick(3);
        chk("shot high", 20'h1, o1_w);
        tick(12);
        chk("shot over", 20'h0, o1_w);
        $display("test outputs done");
    endtask : t_outs

    // Main sequence
    initial begin
        rst = 1'b1;
        sets = '0;
        set_one = 20'h0;
        set_two = 20'h0;
        err_total = 0;
        n_checks = 0;
        tick(16);
        rst = 1'b0;
        t_modes;
        t_clear;
        t_total;
        t_batch;
        t_dual;
        t_tacho;
        t_outs;
        give_verdict;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        $display("BAD watchdog expected done seen hang");
        give_verdict;
    end
endmodule : tb
